// *** verilog/ttp_top.sv ***
/*
 * Front-panel self-test sequencer of a breaker trip unit, with APB access
 * to protection pickups, delays and plug rating, and readback of status.
 * Assumes panel inputs already debounced and synchronous to CLK_I, and a
 * protection core that raises PROT_TRIP_I on a real overload or fault.
 */
`timescale 1ns/10ps
`default_nettype none

module ttp_top
    import ttp_pkg::*;
#(
    parameter int TICK_CYC = TENTH_CYC
) (
    input  wire logic        CLK_I,         // System clock, 40 MHz.
    input  wire logic        SYS_RST_I,     // Asynchronous reset, high.
    input  wire logic        PSEL_I,        // APB select.
    input  wire logic        PENABLE_I,     // APB enable.
    input  wire logic        PWRITE_I,      // APB direction.
    input  wire logic [7:0]  PADDR_I,       // APB byte address.
    input  wire logic [31:0] PWDATA_I,      // APB write data.
    output logic      [31:0] PRDATA_O,      // APB read data.
    output logic             PREADY_O,      // APB ready.
    output logic             PSLVERR_O,     // APB error.
    input  wire logic [2:0]  SELECT_I,      // Test selector position.
    input  wire logic        TEST_PB_I,     // Test pushbutton, high pressed.
    input  wire logic        STEP_PB_I,     // Step pushbutton.
    input  wire logic        RESET_PB_I,    // Trip-reset pushbutton.
    input  wire logic        BATT_PB_I,     // Battery-check pushbutton.
    input  wire logic        BATT_GOOD_I,   // Battery above weak level.
    input  wire logic        CTRL_PWR_I,    // External control power on.
    input  wire logic        LOAD_HIGH_I,   // Load above 40 percent plug.
    input  wire logic        PROT_TRIP_I,   // Real protection trip demand.
    output logic             TRIP_O,        // Breaker trip actuator.
    output logic      [3:0]  FUNC_LED_O,    // LD, SD, INST, GF LEDs.
    output logic      [3:0]  POINTER_O,     // Pointer LEDs A, B, C, G.
    output logic      [2:0]  DISP_MODE_O,   // Display content kind.
    output logic      [19:0] DISP_VAL_O,    // Display numeric value.
    output logic             BATT_LED_O,    // Battery-check LED.
    output logic             TEST_BUSY_O,   // Panel test in progress.
    output logic             ABORT_O        // One-cycle test abort pulse.
);

    ////////////////////////////////////////////////////////////////////////
    // Types, registers and wires.
    typedef enum logic [2:0] {
        ST_IDLE, ST_HOLD, ST_RUN, ST_RES_NT, ST_RES_T
    } ttp_state_e;

    ttp_state_e  state_reg;
    ttp_pickup_s pickup_reg;
    logic [11:0] dly_reg [4];
    logic [15:0] plug_reg;
    logic [31:0] rdata_reg;
    logic        slverr_reg;
    logic [31:0] tick_cnt_reg;
    logic        tick;
    logic [11:0] time_reg;
    logic [15:0] raw_reg;
    logic [2:0]  sel_reg;
    logic [3:0]  led_reg;
    logic [3:0]  ptr_reg;
    logic [1:0]  step_left_reg;
    logic        trip_reg;
    logic        abort_reg;
    logic [19:0] cur_reg;
    logic        test_q, step_q, reset_q;
    logic        test_rel, step_press, reset_press, reset_rel;
    logic [3:0]  picked;
    logic [3:0]  resp;
    logic [11:0] resp_dly;
    logic        run_done;
    logic        trip_pos;
    logic        ground_pos;
    logic        abort_now;
    logic        apb_setup, apb_wr;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Test multiple for a selector position, tenths of plug rating.
    function automatic logic [7:0] sel_mult(input logic [2:0] sel);
        unique case (sel)
            3'h0:    sel_mult = MULT_X1;
            3'h1:    sel_mult = MULT_X2;
            3'h2:    sel_mult = MULT_X3;
            3'h3:    sel_mult = MULT_X6;
            3'h4:    sel_mult = MULT_X8;
            3'h5:    sel_mult = MULT_X10;
            default: sel_mult = MULT_GND;
        endcase
    endfunction : sel_mult

    // True for the positions that drive current into the ground element.
    function automatic logic is_ground(input logic [2:0] sel);
        is_ground = (sel == SEL_GND) || (sel == SEL_GNDT);
    endfunction : is_ground

    ////////////////////////////////////////////////////////////////////////
    // Pushbutton edge detection on synchronous inputs.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            test_q  <= 1'b0;
            step_q  <= 1'b0;
            reset_q <= 1'b0;
        end else begin
            test_q  <= TEST_PB_I;
            step_q  <= STEP_PB_I;
            reset_q <= RESET_PB_I;
        end
    end

    // Release and press strobes.
    assign test_rel    = test_q && !TEST_PB_I;
    assign step_press  = STEP_PB_I && !step_q;
    assign reset_press = RESET_PB_I && !reset_q;
    assign reset_rel   = reset_q && !RESET_PB_I;

    ////////////////////////////////////////////////////////////////////////
    // Test decoding: picked functions, responsible function and delay.
    assign ground_pos = is_ground(sel_reg);
    assign trip_pos   = (sel_reg == SEL_PH6T) || (sel_reg == SEL_GNDT);

    always_comb begin
        picked = 4'h0;
        if (ground_pos) begin
            picked[FN_GF] = pickup_reg.gf < sel_mult(sel_reg);
        end else begin
            picked[FN_LD] = pickup_reg.ld < sel_mult(sel_reg);
            picked[FN_SD] = pickup_reg.sd < sel_mult(sel_reg);
            picked[FN_IN] = pickup_reg.inst < sel_mult(sel_reg);
        end
    end

    // The picked function with the shortest delay is the one that acts.
    always_comb begin
        resp     = 4'h0;
        resp_dly = 12'hfff;
        for (int i = 0; i < 4; i++) begin
            if (picked[i] && (dly_reg[i] < resp_dly || resp == 4'h0)) begin
                resp     = 4'h0;
                resp[i]  = 1'b1;
                resp_dly = dly_reg[i];
            end
        end
    end

    assign run_done  = (resp == 4'h0) || (raw_reg >= {4'h0, resp_dly});
    // Real fault, heavy load or reset press ends any panel test.
    assign abort_now = (state_reg == ST_HOLD || state_reg == ST_RUN) &&
                       (reset_press || LOAD_HIGH_I || PROT_TRIP_I);

    ////////////////////////////////////////////////////////////////////////
    // Tenth-second tick divider, counting only while a test runs.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            tick_cnt_reg <= 32'h0;
        end else if (state_reg != ST_RUN) begin
            tick_cnt_reg <= 32'h0;
        end else if (tick) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

    // Displayed time wraps past 99.9 s; raw time drives the end decision.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            time_reg <= 12'h0;
            raw_reg  <= 16'h0;
        end else if (state_reg == ST_HOLD && test_rel) begin
            time_reg <= 12'h0;
            raw_reg  <= 16'h0;
        end else if (state_reg == ST_RUN && tick && !run_done) begin
            time_reg <= (time_reg == TIME_WRAP) ? 12'h0
                                                : time_reg + 12'h1;
            raw_reg  <= raw_reg + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequencer.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_reg <= ST_IDLE;
            sel_reg   <= 3'h0;
        end else if (abort_now) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (TEST_PB_I && !LOAD_HIGH_I && !PROT_TRIP_I) begin
                        state_reg <= ST_HOLD;
                        sel_reg   <= SELECT_I;
                    end
                end
                ST_HOLD: begin
                    if (test_rel) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (run_done) begin
                        state_reg <= trip_pos ? ST_RES_T : ST_RES_NT;
                    end
                end
                ST_RES_NT, ST_RES_T: begin
                    if (reset_rel) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Abort strobe for observers.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            abort_reg <= 1'b0;
        end else begin
            abort_reg <= abort_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Function LEDs, test trip latch and captured current.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            led_reg  <= 4'h0;
            trip_reg <= 1'b0;
            cur_reg  <= 20'h0;
        end else if (reset_rel || abort_now) begin
            led_reg  <= 4'h0;
            trip_reg <= 1'b0;
            cur_reg  <= 20'h0;
        end else if (state_reg == ST_RUN && run_done) begin
            if (trip_pos) begin
                led_reg  <= resp;
                trip_reg <= (resp != 4'h0);
                cur_reg  <= 20'((24'(sel_mult(sel_reg)) * 24'(plug_reg))
                                / 24'd10);
            end else begin
                led_reg  <= picked;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer LEDs and step counting for the trip message.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ptr_reg       <= PTR_PHASE_A;
            step_left_reg <= 2'h0;
        end else if (reset_rel) begin
            ptr_reg       <= PTR_PHASE_A;
            step_left_reg <= 2'h0;
        end else if (state_reg == ST_RUN && run_done) begin
            step_left_reg <= (trip_pos && resp[FN_LD]) ? 2'h2 : 2'h1;
        end else if (step_press &&
                     (state_reg == ST_RES_NT || state_reg == ST_RES_T)) begin
            if (state_reg == ST_RES_T && step_left_reg != 2'h0) begin
                step_left_reg <= step_left_reg - 2'h1;
            end else begin
                ptr_reg <= {ptr_reg[2:0], ptr_reg[3]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display content, registered.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            DISP_MODE_O <= DISP_BLANK;
            DISP_VAL_O  <= 20'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    DISP_MODE_O <= DISP_BLANK;
                    DISP_VAL_O  <= 20'h0;
                end
                ST_HOLD: begin
                    DISP_MODE_O <= DISP_TEST_MSG;
                    DISP_VAL_O  <= 20'h0;
                end
                ST_RUN, ST_RES_NT: begin
                    DISP_MODE_O <= DISP_TIME;
                    DISP_VAL_O  <= {8'h0, time_reg};
                end
                ST_RES_T: begin
                    if (step_left_reg != 2'h0) begin
                        DISP_MODE_O <= DISP_TRIP_MSG;
                        DISP_VAL_O  <= 20'h0;
                    end else if (ptr_reg == (ground_pos ? PTR_GROUND
                                                        : PTR_PHASE_A)) begin
                        DISP_MODE_O <= DISP_CURRENT;
                        DISP_VAL_O  <= cur_reg;
                    end else begin
                        DISP_MODE_O <= DISP_BLANK;
                        DISP_VAL_O  <= 20'h0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Panel outputs.
    assign TRIP_O      = PROT_TRIP_I || trip_reg;
    // LEDs remain lit from the backup battery without control power.
    assign FUNC_LED_O  = led_reg & {4{CTRL_PWR_I || BATT_GOOD_I}};
    assign POINTER_O   = ptr_reg;
    assign BATT_LED_O  = BATT_PB_I && BATT_GOOD_I;
    assign TEST_BUSY_O = (state_reg == ST_HOLD) || (state_reg == ST_RUN);
    assign ABORT_O     = abort_reg;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.
    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_wr    = PSEL_I && PENABLE_I && PWRITE_I;
    assign PREADY_O  = 1'b1;
    assign PRDATA_O  = rdata_reg;
    assign PSLVERR_O = slverr_reg && PSEL_I && PENABLE_I;

    // Writable setting registers.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pickup_reg    <= RST_PICKUP;
            dly_reg[FN_LD] <= RST_DLY_LD;
            dly_reg[FN_SD] <= RST_DLY_SD;
            dly_reg[FN_IN] <= RST_DLY_IN;
            dly_reg[FN_GF] <= RST_DLY_GF;
            plug_reg      <= RST_PLUG;
        end else if (apb_wr) begin
            unique case (PADDR_I)
                OFS_PICKUP: pickup_reg <= PWDATA_I;
                OFS_DELAY_LS: begin
                    dly_reg[FN_LD] <= PWDATA_I[DLY_LO_POS +: 12];
                    dly_reg[FN_SD] <= PWDATA_I[DLY_HI_POS +: 12];
                end
                OFS_DELAY_IG: begin
                    dly_reg[FN_IN] <= PWDATA_I[DLY_LO_POS +: 12];
                    dly_reg[FN_GF] <= PWDATA_I[DLY_HI_POS +: 12];
                end
                OFS_PLUG: plug_reg <= PWDATA_I[15:0];
                default: ;
            endcase
        end
    end

    // Read mux and address check, sampled in the setup cycle.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rdata_reg  <= 32'h0;
            slverr_reg <= 1'b0;
        end else if (apb_setup) begin
            slverr_reg <= 1'b0;
            unique case (PADDR_I)
                OFS_PICKUP:   rdata_reg <= pickup_reg;
                OFS_DELAY_LS: rdata_reg <= {4'h0, dly_reg[FN_SD],
                                            4'h0, dly_reg[FN_LD]};
                OFS_DELAY_IG: rdata_reg <= {4'h0, dly_reg[FN_GF],
                                            4'h0, dly_reg[FN_IN]};
                OFS_PLUG:     rdata_reg <= {16'h0, plug_reg};
                OFS_STATUS:   rdata_reg <= {2'h0, step_left_reg, sel_reg,
                                            state_reg, trip_reg, 1'b0,
                                            ptr_reg, led_reg, time_reg};
                OFS_DISPLAY:  rdata_reg <= {9'h0, DISP_MODE_O, DISP_VAL_O};
                default: begin
                    rdata_reg  <= 32'h0;
                    slverr_reg <= 1'b1;
                end
            endcase
        end
    end

endmodule : ttp_top

`default_nettype wire

// *** verilog/ttp_pkg.sv ***
/*
 * Package of the front-panel test sequencer: register map, field layouts,
 * reset values, timing figures and the shared enum and struct types.
 * Assumes a 40 MHz system clock and a 32-bit APB register bus.
 */
package ttp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing figures.
    localparam int CLK_PERIOD_NS = 25;
    localparam int TENTH_SEC_NS  = 100000000;
    localparam int TENTH_CYC     = TENTH_SEC_NS / CLK_PERIOD_NS;
    localparam logic [11:0] TIME_WRAP = 12'h3e7;   // 99.9 s in tenths.

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] OFS_PICKUP   = 8'h00;
    localparam logic [7:0] OFS_DELAY_LS = 8'h04;
    localparam logic [7:0] OFS_DELAY_IG = 8'h08;
    localparam logic [7:0] OFS_PLUG     = 8'h0c;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_DISPLAY  = 8'h14;

    // Field positions inside the delay registers.
    localparam int DLY_LO_POS = 0;
    localparam int DLY_HI_POS = 16;

    // Reset values.
    localparam logic [31:0] RST_PICKUP = 32'h0a_64_28_0a;
    localparam logic [11:0] RST_DLY_LD = 12'h064;
    localparam logic [11:0] RST_DLY_SD = 12'h003;
    localparam logic [11:0] RST_DLY_IN = 12'h001;
    localparam logic [11:0] RST_DLY_GF = 12'h002;
    localparam logic [15:0] RST_PLUG   = 16'h0320;

    // Test multiples in tenths of plug rating, by selector position.
    localparam logic [7:0] MULT_X1  = 8'h0a;
    localparam logic [7:0] MULT_X2  = 8'h14;
    localparam logic [7:0] MULT_X3  = 8'h1e;
    localparam logic [7:0] MULT_X6  = 8'h3c;
    localparam logic [7:0] MULT_X8  = 8'h50;
    localparam logic [7:0] MULT_X10 = 8'h64;
    localparam logic [7:0] MULT_GND = 8'h0a;      // 1.0 per unit.

    // Selector positions.
    localparam logic [2:0] SEL_PH6T  = 3'h3;
    localparam logic [2:0] SEL_GND   = 3'h6;
    localparam logic [2:0] SEL_GNDT  = 3'h7;

    // Function bit indices and one-hot pointer patterns.
    localparam int FN_LD = 0;
    localparam int FN_SD = 1;
    localparam int FN_IN = 2;
    localparam int FN_GF = 3;
    localparam logic [3:0] PTR_PHASE_A = 4'h1;
    localparam logic [3:0] PTR_GROUND  = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Shared types.
    typedef enum logic [2:0] {
        DISP_BLANK, DISP_TEST_MSG, DISP_TIME, DISP_TRIP_MSG, DISP_CURRENT
    } ttp_disp_e;

    typedef struct packed {
        logic [7:0] gf;
        logic [7:0] inst;
        logic [7:0] sd;
        logic [7:0] ld;
    } ttp_pickup_s;

endpackage : ttp_pkg

// *** dv/ttp_assertions.sv ***
/* Checker of the panel sequencer, bound to ttp_top.
   Assumes debounced panel inputs synchronous to CLK_I. */
`timescale 1ns/10ps
`default_nettype none
module ttp_assertions
    import ttp_pkg::*;
(
    input wire logic        CLK_I,       // Clock.
    input wire logic        SYS_RST_I,   // Reset.
    input wire logic        TEST_PB_I,   // Test button.
    input wire logic        RESET_PB_I,  // Reset button.
    input wire logic        BATT_PB_I,   // Battery button.
    input wire logic        BATT_GOOD_I, // Battery good.
    input wire logic        CTRL_PWR_I,  // Control power.
    input wire logic        LOAD_HIGH_I, // High load.
    input wire logic        PROT_TRIP_I, // Real trip.
    input wire logic        TRIP_O,      // Trip output.
    input wire logic [3:0]  FUNC_LED_O,  // Function LEDs.
    input wire logic [3:0]  POINTER_O,   // Pointer LEDs.
    input wire logic [2:0]  DISP_MODE_O, // Display kind.
    input wire logic [19:0] DISP_VAL_O,  // Display value.
    input wire logic        BATT_LED_O,  // Battery LED.
    input wire logic        TEST_BUSY_O, // Test running.
    input wire logic        ABORT_O      // Abort pulse.
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // Button still held on a busy test, and its release.
    sequence s_held;
        (TEST_PB_I && TEST_BUSY_O) [*2];
    endsequence
    sequence s_release;
        TEST_BUSY_O && $fell(TEST_PB_I) && !RESET_PB_I && !LOAD_HIGH_I
            && !PROT_TRIP_I;
    endsequence
    // A held button shows the message, a release starts the clock.
    AST_HOLD_MSG: assert property (s_held |-> DISP_MODE_O == DISP_TEST_MSG)
        else $error("test message missing while held");
    AST_RUN_TIME: assert property (s_release |-> ##[2:3] DISP_MODE_O == DISP_TIME)
        else $error("clock not shown after release");
    AST_WRAP: assert property (DISP_MODE_O == DISP_TIME |-> DISP_VAL_O <= 20'h003e7)
        else $error("time beyond 99.9 s");
    AST_RESET_ABORT: assert property (TEST_BUSY_O && $rose(RESET_PB_I) |-> ##[1:2] ABORT_O && !TEST_BUSY_O)
        else $error("reset press did not abort");
    AST_ABORT_PULSE: assert property (ABORT_O |=> !ABORT_O)
        else $error("abort pulse too long");
    AST_LOAD_ABORT: assert property (TEST_BUSY_O && LOAD_HIGH_I |=> !TEST_BUSY_O)
        else $error("test kept under high load");
    AST_PROT_TRIP: assert property (PROT_TRIP_I |-> TRIP_O)
        else $error("real trip not passed on");
    AST_TRIP_MSG: assert property ($rose(TRIP_O) && !PROT_TRIP_I |-> ##[1:2] DISP_MODE_O == DISP_TRIP_MSG)
        else $error("test trip without message");
    AST_CLEAR: assert property ($fell(RESET_PB_I) && !TEST_BUSY_O |-> ##2 DISP_MODE_O == DISP_BLANK && FUNC_LED_O == 4'h0 && POINTER_O == PTR_PHASE_A)
        else $error("results not cleared on release");
    AST_BATT_LED: assert property (BATT_LED_O == (BATT_PB_I && BATT_GOOD_I))
        else $error("battery LED wrong");
    AST_DARK: assert property (!CTRL_PWR_I && !BATT_GOOD_I |-> FUNC_LED_O == 4'h0)
        else $error("LEDs lit without any supply");
endmodule : ttp_assertions
bind ttp_top ttp_assertions ttp_assertions_i (.CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I), .TEST_PB_I(TEST_PB_I), .RESET_PB_I(RESET_PB_I),
    .BATT_PB_I(BATT_PB_I), .BATT_GOOD_I(BATT_GOOD_I),
    .CTRL_PWR_I(CTRL_PWR_I), .LOAD_HIGH_I(LOAD_HIGH_I),
    .PROT_TRIP_I(PROT_TRIP_I), .TRIP_O(TRIP_O), .FUNC_LED_O(FUNC_LED_O),
    .POINTER_O(POINTER_O), .DISP_MODE_O(DISP_MODE_O),
    .DISP_VAL_O(DISP_VAL_O), .BATT_LED_O(BATT_LED_O),
    .TEST_BUSY_O(TEST_BUSY_O), .ABORT_O(ABORT_O));
`default_nettype wire

// *** dv/ttp_operator.sv ***
/* Operator model: presses the test, step and reset buttons.
   Assumes its task is called just after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module ttp_operator (
    input  wire logic clk_i,      // Panel clock.
    output logic      test_pb_o,  // Test button.
    output logic      step_pb_o,  // Step button.
    output logic      reset_pb_o  // Reset button.
);
    logic [2:0] btn_reg = 3'h0;
    // Buttons appear on the panel lines.
    assign {reset_pb_o, step_pb_o, test_pb_o} = btn_reg;
    // Holds button b (0 test, 1 step, 2 reset) n cycles; a gap follows.
    task automatic push(input int b, input int n);
        btn_reg <= 3'h1 << b;
        repeat (n) @(posedge clk_i);
        btn_reg <= 3'h0;
        repeat (3) @(posedge clk_i);
    endtask : push
endmodule : ttp_operator
`default_nettype wire

// *** dv/tb_top.sv ***
/* Bench of the panel sequencer; each scenario checks itself.
   Assumes the operator model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top
    import ttp_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  sel, mode;
    logic        tpb, spb, rpb, bpb, bgood, cpwr, load, prot, saw_abort;
    logic        trip, bled, busy, abort_o;
    logic [3:0]  led, ptr;
    logic [19:0] val;
    int          num_errors = 0;
    int          cmp_count = 0;
    ttp_top #(.TICK_CYC(4)) ttp_top_i (.CLK_I(clk), .SYS_RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SELECT_I(sel),
        .TEST_PB_I(tpb), .STEP_PB_I(spb), .RESET_PB_I(rpb),
        .BATT_PB_I(bpb), .BATT_GOOD_I(bgood), .CTRL_PWR_I(cpwr),
        .LOAD_HIGH_I(load), .PROT_TRIP_I(prot), .TRIP_O(trip),
        .FUNC_LED_O(led), .POINTER_O(ptr), .DISP_MODE_O(mode),
        .DISP_VAL_O(val), .BATT_LED_O(bled), .TEST_BUSY_O(busy),
        .ABORT_O(abort_o));
    ttp_operator ttp_operator_i (.clk_i(clk), .test_pb_o(tpb),
        .step_pb_o(spb), .reset_pb_o(rpb));
    // Clock of 25 ns.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Remembers any abort pulse.
    always @(posedge clk) if (abort_o === 1'b1) saw_abort <= 1'b1;
    // One APB transfer; leaves rd and err.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {err, rd} = {pslverr, prdata};
        {psel, penable} <= 2'h0;
        @(posedge clk);
    endtask : apb
    task automatic start(input logic [2:0] pos);
        sel <= pos;
        ttp_operator_i.push(0, 6);
    endtask : start
    task automatic wait_idle();
        for (int i = 0; i < 6000 && busy === 1'b1; i++) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : wait_idle
    task automatic s_regs();
        apb(0, OFS_PICKUP, 0);
        `CHK(rd, RST_PICKUP)
        apb(0, 8'h18, 0);
        `CHK({err, rd}, 33'h100000000)
        apb(1, OFS_PICKUP, 32'h0564280a);
        apb(0, OFS_PLUG, 0);
        `CHK(rd[15:0], RST_PLUG)
    endtask : s_regs
    task automatic s_notrip();
        logic [2:0]  pos[4] = '{3'h1, 3'h4, 3'h6, 3'h1};
        logic [3:0]  exl[4] = '{4'h1, 4'h3, 4'h8, 4'h1};
        logic [19:0] ext[4] = '{20'h64, 20'h3, 20'h2, 20'h18};
        for (int i = 0; i < 4; i++) begin
            if (i == 3) apb(1, OFS_DELAY_LS, 32'h00030400);
            start(pos[i]);
            wait_idle();
            `CHK({led, mode, val}, {exl[i], 3'h2, ext[i]})
            ttp_operator_i.push(1, 2);
            `CHK({val, mode, trip}, {ext[i], 3'h2, 1'b0})
            ttp_operator_i.push(2, 2);
            `CHK({led, mode}, 7'h00)
        end
    endtask : s_notrip
    task automatic s_trip();
        logic [2:0]  pos[3] = '{3'h3, 3'h7, 3'h3};
        logic [3:0]  exl[3] = '{4'h2, 4'h8, 4'h1};
        int          more[3] = '{0, 3, 0};
        logic [19:0] cur[3] = '{20'h12c0, 20'h320, 20'h12c0};
        apb(1, OFS_DELAY_LS, 32'h00030064);
        for (int i = 0; i < 3; i++) begin
            if (i == 2) apb(1, OFS_DELAY_LS, 32'h00c80005);
            start(pos[i]);
            wait_idle();
            `CHK({trip, led, mode}, {1'b1, exl[i], 3'h3})
            if (i == 2) ttp_operator_i.push(1, 2);
            `CHK(mode, 3'h3)
            repeat (more[i] + 1) ttp_operator_i.push(1, 2);
            `CHK({mode, val}, {3'h4, cur[i]})
            ttp_operator_i.push(1, 2);
            `CHK(mode == 3'h4, 1'b0)
            ttp_operator_i.push(2, 2);
            `CHK({trip, led, ptr, mode}, 12'h008)
        end
        apb(1, OFS_DELAY_LS, 32'h00030064);
    endtask : s_trip
    // Aborts by reset button, high load and a real fault.
    task automatic s_abort();
        for (int i = 0; i < 3; i++) begin
            saw_abort = 1'b0;
            start(3'h1);
            `CHK(busy, 1'b1)
            if (i == 0) ttp_operator_i.push(2, 2);
            {load, prot} <= {i == 1, i == 2};
            repeat (3) @(posedge clk);
            `CHK({busy, saw_abort, trip}, {2'h1, i == 2})
            {load, prot} <= 2'h0;
            ttp_operator_i.push(2, 2);
        end
    endtask : s_abort
    task automatic s_batt();
        bpb <= 1'b1;
        @(posedge clk);
        `CHK(bled, 1'b1)
        bgood <= 1'b0;
        @(posedge clk);
        `CHK(bled, 1'b0)
        {bpb, bgood} <= 2'h1;
        start(3'h4);
        wait_idle();
        cpwr <= 1'b0;
        @(posedge clk);
        `CHK(led, 4'h3)
        bgood <= 1'b0;
        @(posedge clk);
        `CHK(led, 4'h0)
        {cpwr, bgood} <= 2'h3;
        ttp_operator_i.push(2, 2);
    endtask : s_batt
    task automatic finish_test();
        $display("errors %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // Cuts a hung run short.
    initial begin
        #1ms;
        num_errors++;
        finish_test();
    end
    // Reset for two cycles, then the scenarios.
    initial begin
        {psel, penable, pwrite, paddr, pwdata, sel} = '0;
        {bpb, load, prot, saw_abort, bgood, cpwr, rst} = 7'h07;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_regs();
        s_notrip();
        s_trip();
        s_abort();
        s_batt();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
